// ---- hdl/pfdc_defines.vh ----
// register map, field layout and reset values of the feedback divider block
`ifndef PFDC_DEFINES_VH
`define PFDC_DEFINES_VH

// ==========================================================
// register offsets (byte addresses on the plain port)
`define PFDC_ADDR_W          10
`define PFDC_OFS_SWALLOW     10'h013
`define PFDC_OFS_MAIN_LO     10'h014
`define PFDC_OFS_MAIN_HI     10'h015
`define PFDC_OFS_PRESCALE    10'h016
`define PFDC_OFS_STAT_SEL    10'h017
`define PFDC_OFS_OVERRIDE    10'h01d
`define PFDC_OFS_DIV_STATE   10'h01e

// ==========================================================
// field positions
`define PFDC_PRE_MSB         2
`define PFDC_PRE_LSB         0
`define PFDC_BYPASS_BIT      3
`define PFDC_SEL_MSB         7
`define PFDC_SEL_LSB         2
`define PFDC_OVERRIDE_BIT    7

// ==========================================================
// prescaler mode codes
`define PFDC_PRE_FD1         3'h0
`define PFDC_PRE_FD2         3'h1
`define PFDC_PRE_DM32        3'h2
`define PFDC_PRE_DM54        3'h3
`define PFDC_PRE_DM98        3'h4
`define PFDC_PRE_DM1716      3'h5
`define PFDC_PRE_DM3332      3'h6
`define PFDC_PRE_FD3         3'h7

// ==========================================================
// status pin selector codes: ground and the codes that carry live signals
`define PFDC_SEL_GROUND      6'h00
`define PFDC_SEL_NDIV        6'h01
`define PFDC_SEL_ADIV        6'h03
`define PFDC_SEL_PRESC       6'h04

// ==========================================================
// reset values
`define PFDC_RST_PRESCALE    3'h6
`define PFDC_RST_BYPASS      1'h0
`define PFDC_RST_SEL         6'h00
`define PFDC_RST_OVERRIDE    1'h0
`define PFDC_RST_SWALLOW     6'h00
`define PFDC_RST_MAIN        13'h0001

`endif

// ---- hdl/pfdc_ratio.v ----
// prescaler mode decoder: divide ratio and mode class
`timescale 1ns/1ps
`include "pfdc_defines.vh"

module pfdc_ratio (
  input  wire [2:0] mode,        // prescaler mode field
  input  wire       swallow_nz,  // swallow count still nonzero
  output reg  [5:0] ratio,       // prescaler divide ratio
  output reg        dual_mode    // high in dual-modulus modes
);

  // ==========================================================
  // ratio lookup
  // fixed versus dual
  always @* begin
    ratio     = 6'h01;
    dual_mode = 1'b1;
    case (mode)
      `PFDC_PRE_FD1: begin
        ratio     = 6'h01;
        dual_mode = 1'b0;
      end
      `PFDC_PRE_FD2: begin
        ratio     = 6'h02;
        dual_mode = 1'b0;
      end
      `PFDC_PRE_FD3: begin
        ratio     = 6'h03;
        dual_mode = 1'b0;
      end
      `PFDC_PRE_DM32:   ratio = swallow_nz ? 6'h03 : 6'h02;
      // five, low ratio kept as printed
      `PFDC_PRE_DM54:   ratio = swallow_nz ? 6'h05 : 6'h02;
      `PFDC_PRE_DM98:   ratio = swallow_nz ? 6'h09 : 6'h08;
      `PFDC_PRE_DM1716: ratio = swallow_nz ? 6'h11 : 6'h10;
      `PFDC_PRE_DM3332: ratio = swallow_nz ? 6'h21 : 6'h20;
      default: begin
        ratio     = 6'h01;
        dual_mode = 1'b0;
      end
    endcase
  end

endmodule // pfdc_ratio

// ---- hdl/pfdc_prescaler.v ----
// prescaler counter: one output tick per ratio input ticks
`timescale 1ns/1ps

module pfdc_prescaler (
  input  wire       clk_sys,   // system clock
  input  wire       srst,      // synchronous reset, active high
  input  wire       restart,   // restart count from zero
  input  wire       tick_in,   // vco tick enable pulse
  input  wire [5:0] ratio,     // current divide ratio
  output wire       tick_out   // one-cycle prescaler output
);

  reg  [5:0] cnt_reg;          // ticks seen in this period
  wire       last;             // this tick closes the period

  // period ends on the ratio-th tick; ratio 1 passes every tick
  assign last     = (cnt_reg + 6'h01 >= ratio);
  assign tick_out = tick_in & last & ~restart;

  // ==========================================================
  // tick counter
  always @(posedge clk_sys) begin
    if (srst || restart) begin
      cnt_reg <= 6'h00;
    end else if (tick_in) begin
      cnt_reg <= last ? 6'h00 : cnt_reg + 6'h01;
    end
  end

endmodule // pfdc_prescaler

// ---- hdl/pfdc_top.v ----
// feedback divider configuration, counters and status pin select
`timescale 1ns/1ps
`include "pfdc_defines.vh"

// How it works
// - bypass forces main counter to one
// - bypass honoured only in fixed modes
// - codes 000,001,111 fixed; others dual
// - code 010 divides three or two
// - code 011 divides five or two
// - code 100 divides nine or eight
// - code 101 divides seventeen or sixteen
// - code 110 divides 33/32, reset default
// - selection changes only while override clear
module pfdc_top (
  input  wire                   clk_sys,     // 40 MHz system clock
  input  wire                   srst,        // sync reset, active high
  input  wire [`PFDC_ADDR_W-1:0] reg_addr,   // register address
  input  wire [7:0]             reg_wdata,   // register write data
  input  wire                   reg_wr,      // write strobe
  input  wire                   reg_rd,      // read strobe
  output reg  [7:0]             reg_rdata,   // read data, next cycle
  input  wire                   vco_tick,    // feedback clock enable
  output reg                    fb_out,      // feedback divider pulse
  output reg                    status_pin   // selected status signal
);

  // ==========================================================
  // configuration registers
  reg  [2:0]  pre_mode_reg;    // prescaler mode field
  reg         bypass_reg;      // main counter bypass bit
  reg  [5:0]  sel_reg;         // status selector as written
  reg  [5:0]  sel_act_reg;     // selector in force at the pin
  reg         override_reg;    // status pin override bit
  reg  [5:0]  swallow_reg;     // swallow count
  reg  [12:0] main_reg;        // main counter value

  // ==========================================================
  // divider state
  reg  [12:0] main_left_reg;   // prescaler periods left in frame
  reg  [5:0]  swal_left_reg;   // high-ratio periods left
  reg         restart_reg;     // pending restart after config write

  // ==========================================================
  // decoded and derived signals
  wire [5:0]  ratio;           // prescaler ratio now
  wire        dual_mode;       // dual-modulus mode active
  wire        pre_tick;        // prescaler output pulse
  wire        bypass_eff;      // bypass actually applied
  wire [12:0] main_eff;        // main count actually used
  wire        frame_end;       // last prescaler period of frame
  wire        swal_end;        // swallow phase ends on this tick
  wire        wr_cfg;          // write touches divider setup
  wire        sel_write;       // write to the selector
  wire        dual_mode_nz;    // swallow periods still pending

  // ==========================================================
  // address decode helper, used by the write path only; reads use a case
  function is_addr;
    input [`PFDC_ADDR_W-1:0] a;
    input [`PFDC_ADDR_W-1:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  // ==========================================================
  // prescaler ratio decode
  pfdc_ratio u_ratio (
    .mode       (pre_mode_reg),
    .swallow_nz (dual_mode_nz),
    .ratio      (ratio),
    .dual_mode  (dual_mode)
  );

  // the swallow phase only exists in dual-modulus modes; the
  // decoder reports the mode even when this flag is ignored
  assign dual_mode_nz = (swal_left_reg != 6'h00);

  // ==========================================================
  // prescaler counter
  pfdc_prescaler u_presc (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .restart  (restart_reg),
    .tick_in  (vco_tick),
    .ratio    (ratio),
    .tick_out (pre_tick)
  );

  // ==========================================================
  // main counter length
  // fixed modes only
  assign bypass_eff = bypass_reg & ~dual_mode;
  // divide-by-one
  // a zero main count would stall the frame, so it runs as one
  assign main_eff = (bypass_eff || main_reg == 13'h0000) ?
                    13'h0001 : main_reg;

  assign frame_end = pre_tick && (main_left_reg <= 13'h0001);
  assign swal_end  = pre_tick && dual_mode &&
                     (swal_left_reg == 6'h01);

  // any change to ratio, counts or bypass restarts the frame
  assign wr_cfg = reg_wr &&
                  (is_addr(reg_addr, `PFDC_OFS_SWALLOW) ||
                   is_addr(reg_addr, `PFDC_OFS_MAIN_LO) ||
                   is_addr(reg_addr, `PFDC_OFS_MAIN_HI) ||
                   is_addr(reg_addr, `PFDC_OFS_PRESCALE));

  assign sel_write = reg_wr && is_addr(reg_addr, `PFDC_OFS_STAT_SEL);

  // ==========================================================
  // register writes
  always @(posedge clk_sys) begin
    if (srst) begin
      pre_mode_reg <= `PFDC_RST_PRESCALE;
      bypass_reg   <= `PFDC_RST_BYPASS;
      sel_reg      <= `PFDC_RST_SEL;
      override_reg <= `PFDC_RST_OVERRIDE;
      swallow_reg  <= `PFDC_RST_SWALLOW;
      main_reg     <= `PFDC_RST_MAIN;
    end else if (reg_wr) begin
      // prescaler control holds mode and bypass
      if (is_addr(reg_addr, `PFDC_OFS_PRESCALE)) begin
        pre_mode_reg <= reg_wdata[`PFDC_PRE_MSB:`PFDC_PRE_LSB];
        bypass_reg   <= reg_wdata[`PFDC_BYPASS_BIT];
      end
      // selector is always stored so software can read it back
      if (is_addr(reg_addr, `PFDC_OFS_STAT_SEL)) begin
        sel_reg <= reg_wdata[`PFDC_SEL_MSB:`PFDC_SEL_LSB];
      end
      if (is_addr(reg_addr, `PFDC_OFS_OVERRIDE)) begin
        override_reg <= reg_wdata[`PFDC_OVERRIDE_BIT];
      end
      if (is_addr(reg_addr, `PFDC_OFS_SWALLOW)) begin
        swallow_reg <= reg_wdata[5:0];
      end
      if (is_addr(reg_addr, `PFDC_OFS_MAIN_LO)) begin
        main_reg[7:0] <= reg_wdata;
      end
      if (is_addr(reg_addr, `PFDC_OFS_MAIN_HI)) begin
        main_reg[12:8] <= reg_wdata[4:0];
      end
    end
  end

  // ==========================================================
  // selection in force at the status pin
  // a write made while the override is set is stored but never
  // reaches the pin, even if the override clears later
  always @(posedge clk_sys) begin
    if (srst) begin
      sel_act_reg <= `PFDC_RST_SEL;
    end else if (sel_write && !override_reg) begin
      sel_act_reg <= reg_wdata[`PFDC_SEL_MSB:`PFDC_SEL_LSB];
    end
  end

  // ==========================================================
  // restart request, applied one cycle after the write
  // the delay lets the new settings settle in the registers
  always @(posedge clk_sys) begin
    if (srst) begin
      restart_reg <= 1'b1;
    end else begin
      restart_reg <= wr_cfg;
    end
  end

  // ==========================================================
  // main and swallow counters
  // frame length
  // a frame is main_eff prescaler periods; the first swallow of
  // them use the high ratio, giving low ratio * main + swallow ticks (3 * swallow for code 011)
  always @(posedge clk_sys) begin
    if (srst || restart_reg) begin
      main_left_reg <= 13'h0000;
      swal_left_reg <= 6'h00;
    end else if (main_left_reg == 13'h0000) begin
      // load the first frame after a restart
      main_left_reg <= main_eff;
      swal_left_reg <= dual_mode ? swallow_reg : 6'h00;
    end else if (pre_tick) begin
      if (frame_end) begin
        // reload for the next frame
        main_left_reg <= main_eff;
        swal_left_reg <= dual_mode ? swallow_reg : 6'h00;
      end else begin
        main_left_reg <= main_left_reg - 13'h0001;
        if (swal_left_reg != 6'h00) begin
          swal_left_reg <= swal_left_reg - 6'h01;
        end
      end
    end
  end

  // ==========================================================
  // feedback divider output, one pulse per frame
  always @(posedge clk_sys) begin
    if (srst) begin
      fb_out <= 1'b0;
    end else begin
      fb_out <= frame_end && !restart_reg &&
                (main_left_reg != 13'h0000);
    end
  end

  // ==========================================================
  // status pin multiplexer
  // only the live divider signals are routed; every other code
  // drives ground, which keeps the pin quiet on unknown codes
  always @(posedge clk_sys) begin
    if (srst) begin
      status_pin <= 1'b0;
    end else begin
      case (sel_act_reg)
        `PFDC_SEL_NDIV:  status_pin <= frame_end && !restart_reg;
        `PFDC_SEL_ADIV:  status_pin <= swal_end && !restart_reg;
        `PFDC_SEL_PRESC: status_pin <= pre_tick;
        default:         status_pin <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // register reads, data valid one cycle after the strobe
  // unmapped addresses and idle cycles read as zero
  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `PFDC_OFS_SWALLOW:   reg_rdata <= {2'h0, swallow_reg};
        `PFDC_OFS_MAIN_LO:   reg_rdata <= main_reg[7:0];
        `PFDC_OFS_MAIN_HI:   reg_rdata <= {3'h0, main_reg[12:8]};
        `PFDC_OFS_PRESCALE:  reg_rdata <= {4'h0, bypass_reg,
                                           pre_mode_reg};
        `PFDC_OFS_STAT_SEL:  reg_rdata <= {sel_reg, 2'h0};
        `PFDC_OFS_OVERRIDE:  reg_rdata <= {override_reg, 7'h00};
        // live state: selection in force, bypass and mode class
        `PFDC_OFS_DIV_STATE: reg_rdata <= {bypass_eff, dual_mode,
                                           sel_act_reg};
        default:             reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // pfdc_top

// ---- tb/pfdc_top_assertions.sv ----
// checker: port-level assertions of the feedback divider block
`timescale 1ns/1ps
`include "pfdc_defines.vh"
module pfdc_top_assertions (
  input wire                    clk_sys,   // system clock
  input wire                    srst,      // sync reset
  input wire [`PFDC_ADDR_W-1:0] reg_addr,  // address
  input wire [7:0]              reg_wdata, // write data
  input wire                    reg_wr,    // write strobe
  input wire                    reg_rd,    // read strobe
  input wire [7:0]              reg_rdata, // read data
  input wire                    vco_tick,  // tick enable
  input wire                    fb_out,    // frame pulse
  input wire                    status_pin // status pin
);
  // ==========================================
  // shadow of the configuration seen on the bus
  reg [2:0]  mode_reg; // prescaler code
  reg        byp_reg;  // bypass bit
  reg [5:0]  swl_reg;  // swallow count
  reg [12:0] main_reg; // main count
  reg [5:0]  sel_reg;  // stored selection
  reg [5:0]  frc_reg;  // selection in force
  reg        ovr_reg;  // override bit
  reg [1:0]  qt_reg;   // edges since restart
  reg [15:0] gap_reg;  // cycles since last pulse
  reg        ok_reg;   // every tick of frame seen
  wire fx = (mode_reg == 3'h0) || (mode_reg == 3'h1) || (mode_reg == 3'h7);
  // these writes restart the counters
  wire rs_wr = reg_wr && reg_addr >= `PFDC_OFS_SWALLOW
               && reg_addr <= `PFDC_OFS_PRESCALE;
  // frame length with a tick every cycle; swallow must not exceed main
  function [15:0] flen;
    input [2:0]  m;
    input [15:0] s;
    input [15:0] n;
    input        b;
    reg   [15:0] lo;
    reg          f;
    begin
      case (m)
        3'h0: lo = 16'h1;
        3'h4: lo = 16'h8;
        3'h5: lo = 16'h10;
        3'h6: lo = 16'h20;
        3'h7: lo = 16'h3;
        default: lo = 16'h2;
      endcase
      f = (m == 3'h0) || (m == 3'h1) || (m == 3'h7);
      if (n == 16'h0 || (f && b)) n = 16'h1;
      if (f) flen = lo * n;
      else flen = lo * n + s * ((m == 3'h3) ? 16'h3 : 16'h1);
    end
  endfunction
  // mirror writes; the selection applies only with override clear
  always @(posedge clk_sys) begin
    if (srst) begin
      mode_reg <= `PFDC_RST_PRESCALE;
      byp_reg  <= 1'b0;
      swl_reg  <= 6'h00;
      main_reg <= 13'h0001;
      sel_reg  <= 6'h00;
      frc_reg  <= 6'h00;
      ovr_reg  <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `PFDC_OFS_SWALLOW: swl_reg <= reg_wdata[5:0];
        `PFDC_OFS_MAIN_LO: main_reg[7:0] <= reg_wdata;
        `PFDC_OFS_MAIN_HI: main_reg[12:8] <= reg_wdata[4:0];
        `PFDC_OFS_PRESCALE: {byp_reg, mode_reg} <= reg_wdata[3:0];
        `PFDC_OFS_OVERRIDE: ovr_reg <= reg_wdata[7];
        `PFDC_OFS_STAT_SEL: begin
          sel_reg <= reg_wdata[7:2];
          if (!ovr_reg) frc_reg <= reg_wdata[7:2];
        end
        default: ;
      endcase
    end
  end
  // a frame is judged only when armed three edges past any restart
  always @(posedge clk_sys) begin
    if (srst || rs_wr) begin
      qt_reg <= 2'h0;
      ok_reg <= 1'b0;
    end else begin
      if (qt_reg != 2'h3) qt_reg <= qt_reg + 2'h1;
      ok_reg <= fb_out ? (vco_tick && qt_reg == 2'h3) : ok_reg && vco_tick;
    end
    gap_reg <= fb_out ? 16'h1 : gap_reg + 16'h1;
  end
  // ==========================================
  // assertions
  a_prescale_read: assert property (
    @(posedge clk_sys) disable iff (srst)
    reg_rd && reg_addr == `PFDC_OFS_PRESCALE
    |=> reg_rdata == {4'h0, byp_reg, mode_reg})
    else $error("prescaler readback wrong");
  a_sel_read: assert property (
    @(posedge clk_sys) disable iff (srst)
    reg_rd && reg_addr == `PFDC_OFS_STAT_SEL |=> reg_rdata[7:2] == sel_reg)
    else $error("selector readback wrong");
  a_state_read: assert property (
    @(posedge clk_sys) disable iff (srst)
    reg_rd && reg_addr == `PFDC_OFS_DIV_STATE
    |=> reg_rdata == {byp_reg && fx, !fx, frc_reg})
    else $error("state readback wrong");
  a_frame_len: assert property (
    @(posedge clk_sys) disable iff (srst)
    fb_out && ok_reg
    |-> gap_reg == flen(mode_reg, swl_reg, main_reg, byp_reg))
    else $error("frame length wrong");
  a_no_stray: assert property (
    @(posedge clk_sys) disable iff (srst) !vco_tick |=> !fb_out)
    else $error("pulse without tick");
  a_unity_pulse: assert property (
    @(posedge clk_sys) disable iff (srst)
    qt_reg == 2'h3 && mode_reg == 3'h0 && byp_reg && vco_tick |=> fb_out)
    else $error("bypass pulse missing");
  a_ground_pin: assert property (
    @(posedge clk_sys) disable iff (srst)
    frc_reg == 6'h00 && $past(frc_reg) == 6'h00 |-> !status_pin)
    else $error("status pin not ground");
  a_reset_quiet: assert property (
    @(posedge clk_sys) disable iff (srst)
    $fell(srst) |-> !fb_out && !status_pin && reg_rdata == 8'h00)
    else $error("outputs active after reset");
endmodule // pfdc_top_assertions

bind pfdc_top pfdc_top_assertions u_chk (.clk_sys(clk_sys), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vco_tick(vco_tick),
  .fb_out(fb_out), .status_pin(status_pin));

// ---- tb/pfdc_top_tb.sv ----
// testbench: register and divider checks of the feedback divider
`timescale 1ns/1ps
`include "pfdc_defines.vh"
module pfdc_top_tb;
  reg        clk_sys;     // 40 MHz clock
  reg        srst;        // sync reset
  reg  [9:0] reg_addr;    // address
  reg  [7:0] reg_wdata;   // write data
  reg        reg_wr;      // write strobe
  reg        reg_rd;      // read strobe
  reg        vco_tick;    // tick enable
  wire [7:0] reg_rdata;   // read data
  wire       fb_out;      // frame pulse
  wire       status_pin;  // status pin
  integer    err_total;   // mismatches
  integer    check_count; // comparisons
  integer    i;           // case index
  reg  [7:0] rv;          // captured read data
  reg        sf;          // frame pulse seen
  reg        sp;          // status pulse seen
  reg        fx;          // fixed-divide code
  // {mode, bypass, swallow, main, frame length}
  reg [31:0] tc [0:14] = '{32'h01000501, 32'h10000306, 32'h70000309,
    32'h11000302, 32'h2002040a, 32'h20000408, 32'h30010309, 32'h30000306,
    32'h40010211, 32'h40000210, 32'h50010221, 32'h50000110, 32'h60010241,
    32'h60000120, 32'h21010307};
  pfdc_top u_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vco_tick(vco_tick), .fb_out(fb_out),
    .status_pin(status_pin));
  // ==========================================
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // compare one value and count it
  task check(input [15:0] seen, input [15:0] exp, input [63:0] what);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // write; a spare edge keeps strobes from being set twice in one step
  task wr(input [9:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  // read; data stands only in the cycle after the strobe
  task rd(input [9:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge clk_sys);
    end
  endtask
  // gap between second and third pulse; the first may be cut by restart
  task frame(input [15:0] exp);
    integer k;
    integer g;
    integer p;
    begin
      g = 0;
      p = 0;
      for (k = 0; k < 600 && p < 3; k = k + 1) begin
        @(posedge clk_sys);
        #1 g = g + 1;
        if (fb_out === 1'b1) begin
          p = p + 1;
          if (p < 3) g = 0;
        end
      end
      check(g, exp, "frame");
      @(posedge clk_sys);
    end
  endtask
  // watch both pulse outputs for eight cycles
  task watch;
    integer k;
    begin
      sf = 1'b0;
      sp = 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        @(posedge clk_sys);
        #1 sf = sf | fb_out;
        sp = sp | status_pin;
      end
      @(posedge clk_sys);
    end
  endtask
  // verdict and end of run
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // watchdog: the tests need well under 10000 cycles
  initial begin
    #(25 * 20000);
    err_total = err_total + 1;
    complete_run;
  end
  // ==========================================
  // main sequence
  initial begin
    srst = 1'b1;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    vco_tick = 1'b1;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(`PFDC_OFS_PRESCALE);
    check(rv, 8'h06, "pre");
    rd(`PFDC_OFS_STAT_SEL);
    check(rv[7:2], 6'h00, "sel");
    rd(10'h3ff);
    check(rv, 8'h00, "unmap");
    frame(16'h20);
    // every prescaler code, dual codes with and without swallow; upper bits read 0
    for (i = 0; i < 15; i = i + 1) begin
      wr(`PFDC_OFS_SWALLOW, tc[i][23:16]);
      wr(`PFDC_OFS_MAIN_LO, tc[i][15:8]);
      wr(`PFDC_OFS_PRESCALE, {4'hf, tc[i][24], tc[i][30:28]});
      rd(`PFDC_OFS_PRESCALE);
      check(rv, {4'h0, tc[i][24], tc[i][30:28]}, "pre");
      fx = tc[i][30:28] == 3'h0 || tc[i][30:28] == 3'h1
           || tc[i][30:28] == 3'h7;
      rd(`PFDC_OFS_DIV_STATE);
      check(rv[7:6], {tc[i][24] & fx, ~fx}, "state");
      frame(tc[i][7:0]);
    end
    // status pin on frame pulse; selection locked while override set
    wr(`PFDC_OFS_PRESCALE, 8'h08);
    wr(`PFDC_OFS_STAT_SEL, 8'h04);
    watch;
    check(sp, 1'b1, "pin");
    wr(`PFDC_OFS_OVERRIDE, 8'h80);
    wr(`PFDC_OFS_STAT_SEL, 8'h00);
    rd(`PFDC_OFS_STAT_SEL);
    check(rv[7:2], 6'h00, "sel");
    wr(`PFDC_OFS_OVERRIDE, 8'h00);
    rd(`PFDC_OFS_DIV_STATE);
    check(rv[5:0], 6'h01, "force");
    watch;
    check(sp, 1'b1, "pin");
    // swallow-phase end and prescaler pulses reach the pin too
    wr(`PFDC_OFS_PRESCALE, 8'h02);
    wr(`PFDC_OFS_STAT_SEL, 8'h0c);
    watch;
    check(sp, 1'b1, "swal");
    wr(`PFDC_OFS_STAT_SEL, 8'h10);
    watch;
    check(sp, 1'b1, "presc");
    wr(`PFDC_OFS_STAT_SEL, 8'h00);
    watch;
    check(sp, 1'b0, "pin");
    // without ticks no frame may close
    vco_tick <= 1'b0;
    watch;
    check(sf, 1'b0, "fb");
    complete_run;
  end
endmodule // pfdc_top_tb
